/* rtl/rcc_pkg.sv */
// package: register map, field positions, reset values and timing for the reset cause block
package rcc_pkg;
  // register byte addresses (low 16 bits of the virtual address)
  localparam logic [15:0] RCC_CAUSE_ADDR   = 16'hF600;
  localparam logic [15:0] RCC_TRIG_ADDR    = 16'hF010;
  localparam logic [15:0] RCC_IRQ_STAT_ADDR = 16'hF700;
  localparam logic [15:0] RCC_IRQ_MASK_ADDR = 16'hF710;
  localparam logic [15:0] RCC_UNLOCK_ADDR  = 16'hF720;
  // alias offsets inside each 16-byte register slot
  localparam logic [3:0]  RCC_ALIAS_PLAIN  = 4'h0;
  localparam logic [3:0]  RCC_ALIAS_CLR    = 4'h4;
  localparam logic [3:0]  RCC_ALIAS_SET    = 4'h8;
  localparam logic [3:0]  RCC_ALIAS_INV    = 4'hC;
  // cause register bit positions
  localparam int RCC_POR_BIT   = 0;
  localparam int RCC_BOR_BIT   = 1;
  localparam int RCC_IDLE_BIT  = 2;
  localparam int RCC_SLEEP_BIT = 3;
  localparam int RCC_WATCHDOG_TIMEOUT_FLAG_BIT  = 4;
  localparam int RCC_SWR_BIT   = 6;
  localparam int RCC_EXTERNAL_PIN_RESET_FLAG_BIT  = 7;
  localparam int RCC_VREG_BIT  = 8;
  localparam int RCC_CMR_BIT   = 9;
  localparam int RCC_TRIG_BIT  = 0;
  localparam logic [9:0]  RCC_CAUSE_IMPL   = 10'h3DF;
  localparam logic [9:0]  RCC_CAUSE_RESET  = 10'h003;
  localparam logic [9:0]  RCC_CAUSE_HS     = 10'h2DF;
  // two unlock keys written to the unlock register in order
  localparam logic [31:0] RCC_KEY1         = 32'hAA996655;
  localparam logic [31:0] RCC_KEY2         = 32'h556699AA;
  // software reset pulse length
  localparam int RCC_CLK_MHZ     = 10;
  localparam int RCC_SOFT_RESET_TRIGGER_BIT_NS    = 800;
  localparam int RCC_SOFT_RESET_TRIGGER_BIT_CYC   = (RCC_SOFT_RESET_TRIGGER_BIT_NS * RCC_CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  RCC_SOFT_RESET_TRIGGER_BIT_CNT    = 4'(RCC_SOFT_RESET_TRIGGER_BIT_CYC);

  typedef struct packed {
    logic por;
    logic ext_clear;
    logic watchdog;
    logic brownout;
    logic cfg_mismatch;
    logic woke_sleep;
    logic woke_idle;
  } rcc_src_t;

  typedef enum logic [2:0] {
    RCC_RUN   = 3'b001,
    RCC_SOFT_RESET_TRIGGER_BIT = 3'b010,
    RCC_DONE  = 3'b100
  } rcc_state_t;
endpackage

/* rtl/rcc_reset_cause.sv */
// reset cause and master reset logic with apb register slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// How it works
// - all sources except the two wake sources merge into one master reset
// - five sources and the software reset each assert master reset
// - bit 9 set on configuration mismatch
// - bit 8 regulator keep-on, resets zero
// - bit 7 set on external clear pin
// - bit 6 set after software reset
// - bit 4 set on watchdog timeout
// - bit 3 set on wake from sleep
// - bit 2 set on wake from idle
// - bit 1 set on brown-out
// - bit 0 set on power-on
// - flags sticky until software writes zero
// - clear, set, invert aliases at 4,8,C
// - unimplemented cause bits read zero
// - cause value depends on reset kind
// - trigger write one after the two unlock keys starts software reset, self-clears
module rcc_reset_cause (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire rcc_pkg::rcc_src_t src_async,
  output logic                   master_system_reset,
  output logic                   regulator_sleep_keep_on,
  output logic                   irq
);

  // ==========================================================
  // source synchronisers
  rcc_pkg::rcc_src_t src_meta;
  rcc_pkg::rcc_src_t src;
  rcc_pkg::rcc_src_t src_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_meta <= '0;
      src      <= '0;
      src_d    <= '0;
    end else begin
      src_meta <= src_async;
      src      <= src_meta;
      src_d    <= src;
    end
  end

  // rising edges count as one occurrence each, so a held source sets a flag once
  wire rcc_pkg::rcc_src_t src_rise = src & ~src_d;

  // ==========================================================
  // apb decode
  wire        acc      = psel & penable;
  wire        wr       = acc & pwrite;
  wire [15:0] slot     = {paddr[15:4], 4'h0};
  wire [3:0]  alias_of = paddr[3:0];
  wire        hit_cause = slot == rcc_pkg::RCC_CAUSE_ADDR;
  wire        hit_trig  = slot == rcc_pkg::RCC_TRIG_ADDR;
  wire        hit_stat  = slot == rcc_pkg::RCC_IRQ_STAT_ADDR;
  wire        hit_mask  = slot == rcc_pkg::RCC_IRQ_MASK_ADDR;
  wire        hit_unl   = paddr[15:0] == rcc_pkg::RCC_UNLOCK_ADDR;
  wire        mapped    = (paddr[31:16] == 16'h0000) & (paddr[1:0] == 2'h0)
                          & (hit_cause | hit_trig | hit_stat | hit_mask | hit_unl);

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // alias arithmetic on a 10-bit register
  function automatic logic [9:0] rcc_alias(input logic [9:0] cur, input logic [3:0] sel,
                                           input logic [9:0] d);
    logic [9:0] r;
    r = cur;
    unique case (sel)
      rcc_pkg::RCC_ALIAS_PLAIN: r = d;
      rcc_pkg::RCC_ALIAS_CLR:   r = cur & ~d;
      rcc_pkg::RCC_ALIAS_SET:   r = cur | d;
      rcc_pkg::RCC_ALIAS_INV:   r = cur ^ d;
      default:                  r = cur;
    endcase
    return r;
  endfunction

  // ==========================================================
  // unlock sequence
  logic [1:0] unlock;
  wire        wr_unl  = wr & mapped & hit_unl;
  wire        wr_trig = wr & mapped & hit_trig;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock <= 2'h0;
    end else if (wr_unl) begin
      if (pwdata == rcc_pkg::RCC_KEY1)
        unlock <= 2'h1;
      else if (pwdata == rcc_pkg::RCC_KEY2 && unlock == 2'h1)
        unlock <= 2'h2;
      else
        unlock <= 2'h0;
    end else if (wr_trig) begin
      unlock <= 2'h0;
    end
  end

  // new value of trigger bit after any alias
  wire [9:0] trig_new = rcc_alias(10'h000, alias_of, pwdata[9:0]);
  wire       trig_go  = wr_trig & (unlock == 2'h2) & trig_new[rcc_pkg::RCC_TRIG_BIT];

  // ==========================================================
  // software reset sequencer
  rcc_pkg::rcc_state_t state;
  rcc_pkg::rcc_state_t next_state;
  logic [3:0]          cnt;
  always_comb begin
    next_state = state;
    unique case (state)
      rcc_pkg::RCC_RUN:   if (trig_go) next_state = rcc_pkg::RCC_SOFT_RESET_TRIGGER_BIT;
      rcc_pkg::RCC_SOFT_RESET_TRIGGER_BIT: if (cnt == 4'h1) next_state = rcc_pkg::RCC_DONE;
      rcc_pkg::RCC_DONE:  next_state = rcc_pkg::RCC_RUN;
      default:            next_state = rcc_pkg::RCC_RUN;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rcc_pkg::RCC_RUN;
      cnt   <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= (state == rcc_pkg::RCC_RUN) ? rcc_pkg::RCC_SOFT_RESET_TRIGGER_BIT_CNT : cnt - 4'h1;
    end
  end
  wire sw_done = state == rcc_pkg::RCC_DONE;

  // ==========================================================
  // master reset, registered so it cannot glitch
  wire next_master = src.por | src.ext_clear | src.watchdog | src.brownout
                     | src.cfg_mismatch | (state == rcc_pkg::RCC_SOFT_RESET_TRIGGER_BIT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      master_system_reset <= 1'b1;
    else
      master_system_reset <= next_master;
  end

  // ==========================================================
  // cause register; it lives on presetn only, so master reset never wipes it
  logic [9:0] cause;
  logic [9:0] hw_set;
  always_comb begin
    hw_set = 10'h000;
    hw_set[rcc_pkg::RCC_POR_BIT]   = src_rise.por;
    hw_set[rcc_pkg::RCC_BOR_BIT]   = src_rise.brownout;
    hw_set[rcc_pkg::RCC_IDLE_BIT]  = src_rise.woke_idle;
    hw_set[rcc_pkg::RCC_SLEEP_BIT] = src_rise.woke_sleep;
    hw_set[rcc_pkg::RCC_WATCHDOG_TIMEOUT_FLAG_BIT]  = src_rise.watchdog;
    hw_set[rcc_pkg::RCC_SWR_BIT]   = sw_done;
    hw_set[rcc_pkg::RCC_EXTERNAL_PIN_RESET_FLAG_BIT]  = src_rise.ext_clear;
    hw_set[rcc_pkg::RCC_CMR_BIT]   = src_rise.cfg_mismatch;
  end
  wire       wr_cause   = wr & mapped & hit_cause;
  wire [9:0] cause_sw   = wr_cause ? rcc_alias(cause, alias_of, pwdata[9:0]) : cause;
  // set wins over a clear in the same cycle
  wire [9:0] next_cause = (cause_sw | hw_set) & rcc_pkg::RCC_CAUSE_IMPL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cause <= rcc_pkg::RCC_CAUSE_RESET;
    else
      cause <= next_cause;
  end
  assign regulator_sleep_keep_on = cause[rcc_pkg::RCC_VREG_BIT];

  // ==========================================================
  // interrupt status and mask, same layout as cause
  logic [9:0] istat;
  logic [9:0] imask;
  wire  [9:0] ievents  = hw_set & rcc_pkg::RCC_CAUSE_HS;
  wire        wr_stat  = wr & mapped & hit_stat & (alias_of == rcc_pkg::RCC_ALIAS_PLAIN);
  wire        wr_mask  = wr & mapped & hit_mask;
  wire  [9:0] next_istat = ((wr_stat ? istat & ~pwdata[9:0] : istat) | ievents);
  // irq follows the new mask too, so it never lags the status and mask pair by a cycle
  wire  [9:0] next_imask = wr_mask ? (rcc_alias(imask, alias_of, pwdata[9:0]) & rcc_pkg::RCC_CAUSE_HS)
                                   : imask;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat <= 10'h000;
      imask <= 10'h000;
      irq   <= 1'b0;
    end else begin
      istat <= next_istat;
      imask <= next_imask;
      irq   <= |(next_istat & next_imask);
    end
  end

  // ==========================================================
  // read mux; trigger and unlock are write-only and read zero
  wire [9:0] rd_sel = hit_cause ? cause : hit_stat ? istat : hit_mask ? imask : 10'h000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
      prdata <= {22'h000000, rd_sel};
  end

  // ==========================================================
  // checks
  sequence s_trig_ok;
    trig_go;
  endsequence
  sequence s_sw_pulse;
    master_system_reset [*8];
  endsequence

  a_soft_reset_trigger_bit_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
    s_trig_ok |=> ##1 s_sw_pulse ##2 cause[rcc_pkg::RCC_SWR_BIT])
    else $error("software reset pulse or flag wrong");
  a_locked_trigger: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_trig && unlock != 2'h2 && state == rcc_pkg::RCC_RUN) |=> state == rcc_pkg::RCC_RUN)
    else $error("trigger took effect while locked");
  a_source_master: assert property (@(posedge pclk) disable iff (!presetn)
    (src_async.watchdog || src_async.por || src_async.brownout) ##3 1'b1 |-> master_system_reset)
    else $error("source did not assert master reset");
  a_por_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (cause[rcc_pkg::RCC_POR_BIT] && !wr_cause) |=> cause[rcc_pkg::RCC_POR_BIT])
    else $error("power-on flag dropped without write");
  a_ext_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.ext_clear) |=> cause[rcc_pkg::RCC_EXTERNAL_PIN_RESET_FLAG_BIT])
    else $error("external clear flag not set");
  a_cmr_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.cfg_mismatch) |=> cause[rcc_pkg::RCC_CMR_BIT])
    else $error("mismatch flag not set");
  a_wdt_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.watchdog) |=> cause[rcc_pkg::RCC_WATCHDOG_TIMEOUT_FLAG_BIT] && master_system_reset)
    else $error("watchdog flag or reset missing");
  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:10] == 22'h000000 && !prdata[5])
    else $error("unimplemented bits read nonzero");
  a_set_alias: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cause && alias_of == rcc_pkg::RCC_ALIAS_SET && pwdata[rcc_pkg::RCC_VREG_BIT])
    |=> regulator_sleep_keep_on)
    else $error("set alias failed");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(istat & imask))
    else $error("interrupt level mismatch");

  // ==========================================================
  // source checks
  a_por_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.por) |=> cause[rcc_pkg::RCC_POR_BIT] && master_system_reset)
    else $error("power-on flag or reset missing");

  a_bor_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.brownout) |=> cause[rcc_pkg::RCC_BOR_BIT] && master_system_reset)
    else $error("brown-out flag or reset missing");

  a_idle_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.woke_idle) |=> cause[rcc_pkg::RCC_IDLE_BIT])
    else $error("idle wake flag not set");

  a_sleep_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.woke_sleep) |=> cause[rcc_pkg::RCC_SLEEP_BIT])
    else $error("sleep wake flag not set");

  a_ext_master: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.ext_clear) |=> master_system_reset)
    else $error("external clear did not reset");

  a_cmr_master: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.cfg_mismatch) |=> master_system_reset)
    else $error("mismatch did not reset");

  a_master_merge: assert property (@(posedge pclk) disable iff (!presetn)
    (src.por || src.ext_clear || src.watchdog || src.brownout || src.cfg_mismatch)
    |=> master_system_reset)
    else $error("held source lost master reset");

  a_master_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!src.por && !src.ext_clear && !src.watchdog && !src.brownout && !src.cfg_mismatch
     && state != rcc_pkg::RCC_SOFT_RESET_TRIGGER_BIT) |=> !master_system_reset)
    else $error("master reset without a source");

  // ==========================================================
  // interrupt event checks
  a_por_event: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.por) |=> istat[rcc_pkg::RCC_POR_BIT])
    else $error("power-on status not set");

  a_bor_event: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.brownout) |=> istat[rcc_pkg::RCC_BOR_BIT])
    else $error("brown-out status not set");

  a_idle_event: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.woke_idle) |=> istat[rcc_pkg::RCC_IDLE_BIT])
    else $error("idle status not set");

  a_sleep_event: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.woke_sleep) |=> istat[rcc_pkg::RCC_SLEEP_BIT])
    else $error("sleep status not set");

  a_wdt_event: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.watchdog) |=> istat[rcc_pkg::RCC_WATCHDOG_TIMEOUT_FLAG_BIT])
    else $error("watchdog status not set");

  a_ext_event: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.ext_clear) |=> istat[rcc_pkg::RCC_EXTERNAL_PIN_RESET_FLAG_BIT])
    else $error("external clear status not set");

  a_cmr_event: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(src.cfg_mismatch) |=> istat[rcc_pkg::RCC_CMR_BIT])
    else $error("mismatch status not set");

  a_swr_event: assert property (@(posedge pclk) disable iff (!presetn)
    sw_done |=> istat[rcc_pkg::RCC_SWR_BIT])
    else $error("software reset status not set");

  a_irq_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (|(ievents & imask) && !wr_mask) |=> irq)
    else $error("unmasked event gave no interrupt");

  // ==========================================================
  // register and sequencer checks
  a_bor_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (cause[rcc_pkg::RCC_BOR_BIT] && !wr_cause) |=> cause[rcc_pkg::RCC_BOR_BIT])
    else $error("brown-out flag dropped without write");

  a_vreg_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_cause |=> $stable(cause[rcc_pkg::RCC_VREG_BIT]))
    else $error("regulator bit changed by hardware");

  a_swr_source: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(cause[rcc_pkg::RCC_SWR_BIT]) && !$past(wr_cause)) |-> $past(sw_done))
    else $error("software flag set without software reset");

  a_clr_alias: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cause && alias_of == rcc_pkg::RCC_ALIAS_CLR && pwdata[rcc_pkg::RCC_VREG_BIT])
    |=> !regulator_sleep_keep_on)
    else $error("clear alias failed");

  a_inv_alias: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cause && alias_of == rcc_pkg::RCC_ALIAS_INV && pwdata[rcc_pkg::RCC_VREG_BIT])
    |=> cause[rcc_pkg::RCC_VREG_BIT] != $past(cause[rcc_pkg::RCC_VREG_BIT]))
    else $error("invert alias failed");

  a_cause_impl: assert property (@(posedge pclk) disable iff (!presetn)
    (cause & ~rcc_pkg::RCC_CAUSE_IMPL) == 10'h000)
    else $error("unimplemented cause bit set");

  a_high_addr_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && paddr[31:16] != 16'h0000) |-> pslverr)
    else $error("high address gave no error");

  a_trig_start: assert property (@(posedge pclk) disable iff (!presetn)
    trig_go |=> state == rcc_pkg::RCC_SOFT_RESET_TRIGGER_BIT)
    else $error("trigger did not start software reset");

  a_trig_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
    state == rcc_pkg::RCC_DONE |=> state == rcc_pkg::RCC_RUN)
    else $error("trigger did not clear itself");

  a_trig_relock: assert property (@(posedge pclk) disable iff (!presetn)
    wr_trig |=> unlock == 2'h0)
    else $error("trigger write left unlock open");

  a_sw_master: assert property (@(posedge pclk) disable iff (!presetn)
    state == rcc_pkg::RCC_SOFT_RESET_TRIGGER_BIT |=> master_system_reset)
    else $error("software reset did not drive master reset");

  a_sw_count: assert property (@(posedge pclk) disable iff (!presetn)
    state == rcc_pkg::RCC_SOFT_RESET_TRIGGER_BIT |-> cnt != 4'h0)
    else $error("software reset counter ran out");

  a_state_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(state))
    else $error("sequencer state not one-hot");
endmodule

/* sim/rcc_src_model.sv */
// source model: drives reset and wake sources, watches the master reset as the chip does
`timescale 1ns/1ps
module rcc_src_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire logic [2:0]  which,
  input  wire logic [3:0]  hold,
  input  wire logic        master_system_reset,
  output rcc_pkg::rcc_src_t src_async,
  output logic [7:0]       rst_len,
  output logic [7:0]       n_rst
);
  logic [3:0] left;
  logic [7:0] run;
  logic       last;
  // =====================================
  // source levels, held hold+1 cycles so slow and prompt sources both occur
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left      <= 4'h0;
      src_async <= '0;
    end else if (fire) begin
      left      <= hold;
      src_async <= rcc_pkg::rcc_src_t'(7'h01 << which);
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end else begin
      src_async <= '0;
    end
  end
  // =====================================
  // sinks: count master reset pulses and keep the last pulse length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last    <= 1'b1;
      run     <= 8'h00;
      rst_len <= 8'h00;
      n_rst   <= 8'h00;
    end else begin
      last <= master_system_reset;
      run  <= master_system_reset ? run + 8'h01 : 8'h00;
      if (master_system_reset && !last) n_rst <= n_rst + 8'h01;
      if (!master_system_reset && last) rst_len <= run;
    end
  end
endmodule

/* sim/reset_cause_control_tb.sv */
// testbench: reset cause block with apb master and source model
`timescale 1ns/1ps
module reset_cause_control_tb;
  localparam logic [31:0] A_CAUSE = {16'h0000, rcc_pkg::RCC_CAUSE_ADDR};
  localparam logic [31:0] A_TRIG  = {16'h0000, rcc_pkg::RCC_TRIG_ADDR};
  localparam logic [31:0] A_STAT  = {16'h0000, rcc_pkg::RCC_IRQ_STAT_ADDR};
  localparam logic [31:0] A_MASK  = {16'h0000, rcc_pkg::RCC_IRQ_MASK_ADDR};
  localparam logic [31:0] A_KEY   = {16'h0000, rcc_pkg::RCC_UNLOCK_ADDR};
  logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]       paddr = '0, pwdata = '0, prdata, rd, v, ev;
  logic              pready, pslverr, err, mrst, reg_on, irq, fire = 1'b0;
  logic [2:0]        which = '0;
  logic [3:0]        hold = 4'h1, op;
  logic [7:0]        rst_len, n_rst, k;
  rcc_pkg::rcc_src_t src;
  int                n_fail = 0, n_compared = 0;
  // cause bit per source, in struct order from woke_idle upward
  int                cbit [7] = '{2, 3, 9, 1, 4, 7, 0};

  always #50 pclk = ~pclk;

  rcc_reset_cause u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_async(src),
    .master_system_reset(mrst), .regulator_sleep_keep_on(reg_on), .irq(irq));
  rcc_src_model u_src (.pclk(pclk), .presetn(presetn), .fire(fire), .which(which), .hold(hold),
    .master_system_reset(mrst), .src_async(src), .rst_len(rst_len), .n_rst(n_rst));

  // =====================================
  // shared tasks
  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) n_fail++;
    if (i == 16) results();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected cause after a write through one of the four aliases
  function automatic logic [31:0] alias_f(logic [31:0] c, logic [3:0] o, logic [31:0] d);
    case (o)
      4'h4: c = c & ~d;
      4'h8: c = c | d;
      4'hC: c = c ^ d;
      default: c = d;
    endcase
    return c & 32'h000003DF;
  endfunction
  task automatic fire_src(input int i);
    @(posedge pclk);
    hold  <= 4'($urandom_range(1, 9));
    which <= 3'(i);
    fire  <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (18) @(posedge pclk);
  endtask

  // =====================================
  // main sequence
  initial begin
    void'($urandom(32'hB69D));
    repeat (3) @(posedge pclk);
    chk("reset held", 32'h1, mrst);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause at reset", 32'h3, rd);
    chk("mapped error", 32'h0, err);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, A_CAUSE, 32'h0);
      k = n_rst;
      fire_src(i);
      chk("reset out", 32'h0, mrst);
      chk("reset pulses", k + 8'(i > 1), n_rst);
      apb(1'b0, A_CAUSE, 32'h0);
      chk("cause flag", 32'h1 << cbit[i], rd);
    end
    ev = 32'h0;
    apb(1'b1, A_CAUSE, ev);
    for (int j = 0; j < 8; j++) begin
      op = 4'($urandom_range(0, 3)) << 2;
      v  = (j == 0) ? 32'hFFFFFFFF : $urandom;
      apb(1'b1, A_CAUSE | 32'(op), v);
      ev = alias_f(ev, op, v);
      apb(1'b0, A_CAUSE, 32'h0);
      chk("cause alias", ev, rd);
      chk("regulator", 32'(ev[8]), reg_on);
    end
    // bad addresses answer with an error and leave the cause alone
    apb(1'b0, 32'h0000F900, 32'h0);
    chk("unmapped error", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 32'h0001F600, 32'h3FF);
    chk("high address error", 32'h1, err);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause kept", ev, rd);
    // interrupt from a wake source, so no master reset disturbs the mask
    apb(1'b1, A_STAT, 32'h3FF);
    apb(1'b1, A_MASK, 32'h8);
    fire_src(1);
    chk("irq raised", 32'h1, irq);
    apb(1'b1, A_MASK | 32'h4, 32'h8);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, irq);
    apb(1'b1, A_MASK | 32'h8, 32'h8);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", 32'h1, irq);
    apb(1'b1, A_STAT, 32'h8);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, irq);
    // software reset: locked write ignored, unlocked write runs
    apb(1'b1, A_CAUSE, 32'h0);
    k = n_rst;
    apb(1'b1, A_TRIG, 32'h1);
    repeat (12) @(posedge pclk);
    chk("locked trigger", k, n_rst);
    apb(1'b1, A_KEY, rcc_pkg::RCC_KEY1);
    apb(1'b1, A_KEY, rcc_pkg::RCC_KEY2);
    apb(1'b1, A_TRIG | 32'h8, 32'h1);
    repeat (14) @(posedge pclk);
    chk("soft reset count", k + 8'h01, n_rst);
    chk("soft reset length", rcc_pkg::RCC_SOFT_RESET_TRIGGER_BIT_CYC, rst_len);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("soft flag", 32'h40, rd);
    apb(1'b0, A_TRIG, 32'h0);
    chk("trigger reads", 32'h0, rd);
    results();
  end
endmodule
